// File: logic/supply_ctl_cfg.svh
// Purpose: Offsets, field positions, reset values and code values for the
//          supply output configuration logic.
// Assumes: Avalon-MM byte addresses, one 32-bit word per register.
// Notes:   Definitions only.
`ifndef SUPPLY_CTL_CFG_SVH
`define SUPPLY_CTL_CFG_SVH

// ====================================================================
// Register byte offsets
`define OFS_CMD        6'h00
`define OFS_OFF_MODE   6'h04
`define OFS_VLIM       6'h08
`define OFS_CLIM       6'h0C
`define OFS_MAIN       6'h10
`define OFS_OFF_VLVL   6'h14
`define OFS_OFF_CLVL   6'h18
`define OFS_WINDOW     6'h1C
`define OFS_ERR_MASK   6'h20
`define OFS_OPTIONS    6'h24
`define OFS_STATUS     6'h28
`define OFS_REPLY      6'h2C
`define OFS_REPLY_PUT  6'h30
`define OFS_SERIAL     6'h34

// ====================================================================
// Command register bits (write-only pulses)
`define CMD_OUT_ON     0
`define CMD_OUT_OFF    1
`define CMD_RESET      2
`define CMD_DEV_CLEAR  3
`define CMD_MEM_UPDATE 4
`define CMD_FACTORY    5
`define CMD_STRING_RX  6

// Off-state limit mode bits
`define OFFM_VMAX      0
`define OFFM_IMAX      1
`define OFFM_VLVL      2
`define OFFM_ILVL      3

// Error response mask bits
`define ERR_WIN_EN     0
`define ERR_WIN_OFF    1
`define ERR_ILIM_EN    2
`define ERR_ILIM_OFF   3
`define ERR_HARD_EN    4
`define ERR_HARD_OFF   5

// Status bits
`define ST_WIN_Q       0
`define ST_WIN_ERR     1
`define ST_ILIM_ERR    2
`define ST_HARD_ERR    3
`define ST_OUT_ON      8
`define ST_VMODE       9
`define ST_REPLY_FULL  10

// ====================================================================
// Reset and code values
`define RST_WINDOW     16'h0020
`define LIM_ZERO       12'h000
`define LIM_MAX        12'hFFF
`define MAIN_ZERO      16'h8000
`define LINE_FEED      8'h0A
`define MEAS_FULL      16'hFFFF
`define LOW_RANGE_DIV  16'h000A
`define PERSIST_RST    '{4'h0, `LIM_ZERO, `LIM_ZERO, `RST_WINDOW, 8'h00, 3'h0}

`endif

// File: logic/supply_ctl_pkg.sv
// Purpose: Types shared by the supply output configuration logic.
// Assumes: Constants come from supply_ctl_cfg.svh.
// Notes:   Types only.
package supply_ctl_pkg;

  typedef struct packed {
    logic lf_on_empty;
    logic clear_as_reset;
    logic reset_out_on;
  } options_t;

  typedef struct packed {
    logic [3:0]  off_mode;
    logic [11:0] off_vlvl;
    logic [11:0] off_clvl;
    logic [15:0] window;
    logic [7:0]  err_mask;
    options_t    opts;
  } persist_t;

  typedef struct packed {
    logic ctrl;
    logic data;
    logic clk;
    logic sel2;
    logic sel3;
  } serial_t;

  typedef enum logic [2:0] {
    SER_IDLE   = 3'b001,
    SER_SHIFT  = 3'b010,
    SER_DECODE = 3'b100
  } ser_state_t;

endpackage

// File: logic/supply_ctl.sv
// Contract
// R1: Control high means command mode, shift data
// R2: Return shifted data delayed four bits
// R3: Control low with select set: latch data
// R4: Selects low: hold latches, one chip select
// R5: Limit codes linear, 000 zero, FFF full
// R6: Main code 8000 zero, 0000/FFFF extremes
// R7: Below ten percent use low range
// R8: Compare main against setting, 32 LSB window
// R9: Commands change RAM; update copies to storage
// R10: Window, limit, hard errors; optional off
// R11: Off mode 0 drives both limits zero
// R12: Bit0 voltage max, bit1 current max
// R13: Bits 2,3 use programmed off levels
// R14: Maximum bit overrides programmed level
// R15: Factory restore resets all variables
// R16: Line-feed option 1: empty read gives LF
// R17: Line-feed option 0: each string echoes LF
// R18: Clear option 0: only clear status
// R19: Clear option 1: act like reset
// R20: Reset-output 0: reset turns output off
// R21: Reset-output 1: reset leaves output on
// R22: Data changes while clock idle; sample edge
//
// Purpose: Control logic of a bus-programmed supply interface card.
// Assumes: Avalon-MM slave with waitrequest; serial lines from pins.
// Notes:   Stored copies live in flops loaded with defaults at reset.
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "supply_ctl_cfg.svh"
module supply_ctl
  import supply_ctl_pkg::*;
#(
  parameter int NUM_LATCH = 8,
  parameter int NUM_CS    = 4
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 nrst_i,
  // Avalon-MM slave
  input  wire logic [5:0]           address_i,
  input  wire logic                 read_i,
  input  wire logic                 write_i,
  input  wire logic [31:0]          writedata_i,
  output logic      [31:0]          readdata_o,
  output logic                      waitrequest_o,
  // Isolated serial lines
  input  wire serial_t              ser_i,
  output logic                      loopback_o,
  output logic      [NUM_LATCH-1:0] out_latch_o,
  output logic      [NUM_CS-1:0]    chip_sel_o,
  // Converter codes and output state
  output logic      [11:0]          vlim_dac_o,
  output logic      [11:0]          clim_dac_o,
  output logic      [15:0]          main_dac_o,
  output logic                      output_on_o,
  output logic                      vmode_o,
  // Measurements and error inputs
  input  wire logic [15:0]          meas_main_i,
  input  wire logic [15:0]          meas_v_i,
  input  wire logic [15:0]          meas_i_i,
  input  wire logic                 i_at_limit_i,
  input  wire logic                 i_over_hard_i,
  output logic                      low_range_o,
  output logic                      save_area_clear_o
);

  // ==================================================================
  // Helpers
  function automatic logic [15:0] abs_diff(input logic [15:0] a,
                                           input logic [15:0] b);
    abs_diff = (a > b) ? a - b : b - a;
  endfunction
  function automatic logic is_low(input logic [15:0] m);
    is_low = ({16'h0000, m} * {16'h0000, `LOW_RANGE_DIV})
             < {16'h0000, `MEAS_FULL};
  endfunction
  // R11 R12 R13 off-state level
  // R14 maximum wins
  function automatic logic [11:0] off_lim(input logic mx, input logic lv,
                                          input logic [11:0] lvl);
    off_lim = mx ? `LIM_MAX : (lv ? lvl : `LIM_ZERO);
  endfunction
  // ==================================================================
  // Declarations
  persist_t          ram_reg;
  persist_t          nv_reg;
  logic              load_pend_reg;
  logic [11:0]       vlim_reg;
  logic [11:0]       clim_reg;
  logic [15:0]       main_reg;
  logic              out_on_reg;
  logic              vmode_reg;
  logic [3:0]        status_reg;
  logic [7:0]        reply_reg;
  logic              reply_full_reg;
  logic              rd_ack_reg;
  logic [31:0]       rdata_reg;
  logic              save_clr_reg;
  serial_t           s1_reg;
  serial_t           s2_reg;
  serial_t           s3_reg;
  serial_t           filt_reg;
  ser_state_t        ser_state_reg;
  logic [3:0]        shift_reg;
  logic [NUM_LATCH-1:0] latch_reg;
  logic [NUM_CS-1:0] cs_reg;
  logic              clk_rise;
  logic              ctrl_fall;
  logic              wr_acc;
  logic              rd_acc;
  logic              rd_stall;
  logic [7:0]        cmd;
  logic              do_reset;
  logic              clear_status;
  logic              win_out;
  logic [3:0]        ev_set;
  logic              force_off;
  // ==================================================================
  // Bus handshake
  assign rd_stall = (address_i == `OFS_REPLY) && !reply_full_reg
                    && !ram_reg.opts.lf_on_empty;
  assign waitrequest_o = read_i && !rd_ack_reg;
  assign rd_acc = read_i && rd_ack_reg;
  assign wr_acc = write_i;
  assign cmd = (wr_acc && address_i == `OFS_CMD) ? writedata_i[7:0]
                                                 : 8'h00;
  assign readdata_o = rdata_reg;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rd_ack_reg <= 1'b0;
    end else begin
      rd_ack_reg <= read_i && !rd_ack_reg && !rd_stall;
    end
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (read_i && !rd_ack_reg) begin
      case (address_i)
        `OFS_OFF_MODE: rdata_reg <= {28'h0, ram_reg.off_mode};
        `OFS_VLIM:     rdata_reg <= {20'h0, vlim_reg};
        `OFS_CLIM:     rdata_reg <= {20'h0, clim_reg};
        `OFS_MAIN:     rdata_reg <= {16'h0, main_reg};
        `OFS_OFF_VLVL: rdata_reg <= {20'h0, ram_reg.off_vlvl};
        `OFS_OFF_CLVL: rdata_reg <= {20'h0, ram_reg.off_clvl};
        `OFS_WINDOW:   rdata_reg <= {16'h0, ram_reg.window};
        `OFS_ERR_MASK: rdata_reg <= {24'h0, ram_reg.err_mask};
        `OFS_OPTIONS:  rdata_reg <= {29'h0, ram_reg.opts};
        `OFS_STATUS:   rdata_reg <= {21'h0, reply_full_reg, vmode_reg,
                                     out_on_reg, 4'h0, status_reg};
        // R16 empty read gives LF
        `OFS_REPLY:    rdata_reg <= {24'h0, reply_full_reg ? reply_reg
                                                   : `LINE_FEED};
        `OFS_SERIAL:   rdata_reg <= {20'h0, cs_reg, latch_reg};
        default:       rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  // ==================================================================
  // Reply buffer, one byte deep
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reply_reg      <= 8'h00;
      reply_full_reg <= 1'b0;
    end else if (cmd[`CMD_STRING_RX] && !ram_reg.opts.lf_on_empty) begin
      // R17 echo null string
      reply_reg      <= `LINE_FEED;
      reply_full_reg <= 1'b1;
    end else if (wr_acc && address_i == `OFS_REPLY_PUT) begin
      reply_reg      <= writedata_i[7:0];
      reply_full_reg <= 1'b1;
    end else if (rd_acc && address_i == `OFS_REPLY) begin
      reply_full_reg <= 1'b0;
    end
  end
  // ==================================================================
  // Working and stored configuration
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      load_pend_reg <= 1'b1;
    end else begin
      load_pend_reg <= 1'b0;
    end
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ram_reg <= `PERSIST_RST;
    end else if (load_pend_reg) begin
      // R9 power-up load
      ram_reg <= nv_reg;
    end else if (cmd[`CMD_FACTORY]) begin
      // R15 factory defaults
      ram_reg <= `PERSIST_RST;
    end else if (wr_acc) begin
      // R9 RAM copies only
      case (address_i)
        `OFS_OFF_MODE: ram_reg.off_mode <= writedata_i[3:0];
        `OFS_OFF_VLVL: ram_reg.off_vlvl <= writedata_i[11:0];
        `OFS_OFF_CLVL: ram_reg.off_clvl <= writedata_i[11:0];
        `OFS_WINDOW:   ram_reg.window   <= writedata_i[15:0];
        `OFS_ERR_MASK: ram_reg.err_mask <= writedata_i[7:0];
        `OFS_OPTIONS:  ram_reg.opts     <= writedata_i[2:0];
        default:       ram_reg          <= ram_reg;
      endcase
    end
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_reg <= `PERSIST_RST;
    end else if (cmd[`CMD_FACTORY]) begin
      // R15 saved options cleared
      nv_reg <= `PERSIST_RST;
    end else if (cmd[`CMD_MEM_UPDATE]) begin
      // R9 explicit update
      nv_reg <= ram_reg;
    end
  end
  // R15 clear saved setups
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      save_clr_reg <= 1'b0;
    end else begin
      save_clr_reg <= cmd[`CMD_FACTORY];
    end
  end
  assign save_area_clear_o = save_clr_reg;
  // ==================================================================
  // Output state, reset and device clear
  // R19 clear option 1
  assign do_reset = cmd[`CMD_RESET] || cmd[`CMD_FACTORY] ||
                    (cmd[`CMD_DEV_CLEAR] && ram_reg.opts.clear_as_reset);
  // R18 clear option 0
  assign clear_status = cmd[`CMD_DEV_CLEAR];
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vlim_reg <= `LIM_ZERO;
      clim_reg <= `LIM_ZERO;
      main_reg <= `MAIN_ZERO;
    end else if (do_reset) begin
      vlim_reg <= `LIM_ZERO;
      clim_reg <= `LIM_ZERO;
      main_reg <= `MAIN_ZERO;
    end else if (wr_acc && address_i == `OFS_VLIM) begin
      vlim_reg <= writedata_i[11:0];
    end else if (wr_acc && address_i == `OFS_CLIM) begin
      clim_reg <= writedata_i[11:0];
    end else if (wr_acc && address_i == `OFS_MAIN) begin
      main_reg <= writedata_i[15:0];
    end
  end
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_on_reg <= 1'b0;
      vmode_reg  <= 1'b1;
    end else if (do_reset) begin
      // R20 R21 reset output state
      out_on_reg <= ram_reg.opts.reset_out_on;
      vmode_reg  <= 1'b1;
    end else if (force_off || cmd[`CMD_OUT_OFF]) begin
      out_on_reg <= 1'b0;
    end else if (cmd[`CMD_OUT_ON]) begin
      out_on_reg <= 1'b1;
    end
  end
  assign output_on_o = out_on_reg;
  assign vmode_o     = vmode_reg;
  // ==================================================================
  // Converter codes
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      vlim_dac_o <= `LIM_ZERO;
      clim_dac_o <= `LIM_ZERO;
      main_dac_o <= `MAIN_ZERO;
    end else if (out_on_reg) begin
      // R5 R6 linear codes
      vlim_dac_o <= vlim_reg;
      clim_dac_o <= clim_reg;
      main_dac_o <= main_reg;
    end else begin
      main_dac_o <= `MAIN_ZERO;
      vlim_dac_o <= off_lim(ram_reg.off_mode[`OFFM_VMAX],
                            ram_reg.off_mode[`OFFM_VLVL], ram_reg.off_vlvl);
      clim_dac_o <= off_lim(ram_reg.off_mode[`OFFM_IMAX],
                            ram_reg.off_mode[`OFFM_ILVL], ram_reg.off_clvl);
    end
  end
  // ==================================================================
  // Measurement range and error checks
  // R7 low range select
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      low_range_o <= 1'b0;
    end else begin
      low_range_o <= is_low(meas_v_i) && is_low(meas_i_i);
    end
  end
  // R8 window compare
  assign win_out = out_on_reg &&
                   (abs_diff(meas_main_i, main_reg) > ram_reg.window);
  // R10 configurable errors
  assign ev_set[`ST_WIN_Q]    = win_out;
  assign ev_set[`ST_WIN_ERR]  = win_out && ram_reg.err_mask[`ERR_WIN_EN];
  assign ev_set[`ST_ILIM_ERR] = out_on_reg && i_at_limit_i &&
                                ram_reg.err_mask[`ERR_ILIM_EN];
  assign ev_set[`ST_HARD_ERR] = out_on_reg && i_over_hard_i &&
                                ram_reg.err_mask[`ERR_HARD_EN];
  assign force_off = (ev_set[`ST_WIN_ERR] &&
                      ram_reg.err_mask[`ERR_WIN_OFF]) ||
                     (ev_set[`ST_ILIM_ERR] &&
                      ram_reg.err_mask[`ERR_ILIM_OFF]) ||
                     (ev_set[`ST_HARD_ERR] &&
                      ram_reg.err_mask[`ERR_HARD_OFF]);
  // Sticky bits: a new event beats a clear in the same cycle
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      status_reg <= 4'h0;
    end else if (clear_status || do_reset) begin
      status_reg <= ev_set;
    end else if (wr_acc && address_i == `OFS_STATUS) begin
      status_reg <= (status_reg & ~writedata_i[3:0]) | ev_set;
    end else begin
      status_reg <= status_reg | ev_set;
    end
  end
  // ==================================================================
  // Serial line synchroniser
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
      filt_reg <= '0;
    end else begin
      s1_reg <= ser_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (int i = 0; i < 5; i++) begin
        if (s2_reg[i] == s3_reg[i]) begin
          filt_reg[i] <= s3_reg[i];
        end
      end
    end
  end
  // R22 sample on active edge
  assign clk_rise  = (s2_reg.clk == s3_reg.clk) && s3_reg.clk &&
                     !filt_reg.clk;
  assign ctrl_fall = (s2_reg.ctrl == s3_reg.ctrl) && !s3_reg.ctrl &&
                     filt_reg.ctrl;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ser_state_reg <= SER_IDLE;
    end else begin
      case (ser_state_reg)
        SER_IDLE:   ser_state_reg <= filt_reg.ctrl ? SER_SHIFT : SER_IDLE;
        SER_SHIFT:  ser_state_reg <= ctrl_fall ? SER_DECODE : SER_SHIFT;
        SER_DECODE: ser_state_reg <= filt_reg.ctrl ? SER_SHIFT : SER_IDLE;
        default:    ser_state_reg <= SER_IDLE;
      endcase
    end
  end
  // R1 command mode shift
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      shift_reg <= 4'h0;
    end else if (filt_reg.ctrl && clk_rise) begin
      shift_reg <= {shift_reg[2:0], filt_reg.data};
    end
  end
  // R2 four bit delay
  assign loopback_o = shift_reg[3];
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_reg <= '0;
    end else if (ser_state_reg == SER_DECODE &&
                 (filt_reg.sel2 || filt_reg.sel3)) begin
      // R3 set or clear
      latch_reg[shift_reg[$clog2(NUM_LATCH)-1:0]] <= filt_reg.data;
    end
  end
  assign out_latch_o = latch_reg;
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cs_reg <= '0;
    end else if (filt_reg.ctrl || filt_reg.sel2 || filt_reg.sel3) begin
      cs_reg <= '0;
    end else if (ser_state_reg == SER_DECODE) begin
      // R4 one chip select
      cs_reg <= NUM_CS'(1) << shift_reg[$clog2(NUM_CS)-1:0];
    end
  end
  assign chip_sel_o = cs_reg;
endmodule

// File: verification/serial_ctl_model.sv
// Purpose: Controller side of the isolated control, data and clock lines.
// Assumes: Frames of four bits, first bit sent first.
// Notes:   The serial clock stands low between frames.
`timescale 1ns/1ps
module serial_ctl_model
  import supply_ctl_pkg::*;
(
  // Clock and isolated lines
  input  wire logic mclk_i,
  output serial_t   ser_o
);
  initial ser_o = 5'h00;

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask

  // ==================================================================
  // Frame driver
  task automatic send(input logic [3:0] bits, input logic [1:0] sel,
                      input logic d);
    @(posedge mclk_i);
    ser_o <= 5'h10;
    for (int k = 3; k >= 0; k--) begin
      // data moves only while clock low
      tick(8);
      ser_o.data <= bits[k];
      tick(8);
      ser_o.clk <= 1'b1;
      tick(8);
      ser_o.clk <= 1'b0;
    end
    tick(8);
    ser_o <= {1'b0, d, 1'b0, sel[0], sel[1]};
    tick(12);
  endtask
endmodule

// File: verification/supply_ctl_assertions.sv
// Purpose: Port assertions for the supply control logic.
// Assumes: Bound onto supply_ctl; one clock domain.
// Notes:   Codes reach the pins two edges after a write.
`timescale 1ns/1ps
`include "supply_ctl_cfg.svh"
module supply_ctl_assertions #(
  parameter int NUM_CS = 4
) (
  // Clock, reset and bus
  input wire logic              mclk_i,
  input wire logic              nrst_i,
  input wire logic [5:0]        address_i,
  input wire logic              write_i,
  input wire logic [31:0]       writedata_i,
  // Outputs and measurements
  input wire logic [NUM_CS-1:0] chip_sel_o,
  input wire logic [11:0]       vlim_dac_o,
  input wire logic [11:0]       clim_dac_o,
  input wire logic [15:0]       main_dac_o,
  input wire logic              output_on_o,
  input wire logic              vmode_o,
  input wire logic [15:0]       meas_v_i,
  input wire logic [15:0]       meas_i_i,
  input wire logic              low_range_o,
  input wire logic              save_area_clear_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic cmd_w;
  assign cmd_w = write_i && address_i == `OFS_CMD;

  // ==================================================================
  // Converter codes
  vlim_pass_a: assert property (
    output_on_o && write_i && address_i == `OFS_VLIM
    |-> ##2 vlim_dac_o == $past(writedata_i[11:0], 2))
    else $error("vlim code");
  clim_pass_a: assert property (
    output_on_o && write_i && address_i == `OFS_CLIM
    |-> ##2 clim_dac_o == $past(writedata_i[11:0], 2))
    else $error("clim code");
  main_pass_a: assert property (
    output_on_o && write_i && address_i == `OFS_MAIN
    |-> ##2 main_dac_o == $past(writedata_i[15:0], 2))
    else $error("main code");
  // Registered, so the first edge after reset is skipped
  low_range_a: assert property (
    $past(nrst_i) |-> low_range_o == (({4'h0, $past(meas_v_i)} * 20'h0000A
    < 20'h0FFFF) && ({4'h0, $past(meas_i_i)} * 20'h0000A < 20'h0FFFF)))
    else $error("low range select");

  // ==================================================================
  // Commands and selects
  reset_state_a: assert property (
    cmd_w && writedata_i[`CMD_RESET] |-> ##[1:2]
    main_dac_o == `MAIN_ZERO && vmode_o) else $error("reset state");
  factory_clear_a: assert property (
    cmd_w && writedata_i[`CMD_FACTORY] |-> ##[1:2] save_area_clear_o)
    else $error("save area clear missing");
  clear_pulse_a: assert property (
    save_area_clear_o |=> !save_area_clear_o) else $error("clear too long");
  cs_onehot_a: assert property (
    $onehot0(chip_sel_o)) else $error("chip select not one-hot");

  cover property (save_area_clear_o);
  cover property (chip_sel_o != '0);
  cover property (low_range_o ##1 !low_range_o);
endmodule

// File: verification/testbench.sv
// Purpose: Self-checking bench for the supply control logic.
// Assumes: Avalon master tasks; a model drives the isolated lines.
// Notes:   Read data is checked off a queue by a monitor process.
`timescale 1ns/1ps
`include "supply_ctl_cfg.svh"
module testbench
  import supply_ctl_pkg::*;
;
  typedef struct {logic [31:0] v; logic [31:0] m;} note_t;
  logic        mclk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic [5:0]  address_i = 6'h00;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [15:0] meas_main_i = 16'h0;
  logic [15:0] meas_v_i = 16'h0;
  logic [15:0] meas_i_i = 16'h0100;
  logic        i_at_limit_i = 1'b0;
  logic        i_over_hard_i = 1'b0;
  serial_t     ser_i;
  logic [31:0] readdata_o;
  logic        waitrequest_o, loopback_o, output_on_o, vmode_o;
  logic        low_range_o, save_area_clear_o;
  logic [7:0]  out_latch_o;
  logic [3:0]  chip_sel_o;
  logic [11:0] vlim_dac_o, clim_dac_o, r1, r2;
  logic [15:0] main_dac_o;
  logic [15:0] mains[3] = '{16'h0000, 16'hFFFF, 16'h8000};
  logic [3:0]  mode;
  note_t       notes[$];
  int          mismatches = 0, comparisons = 0, seed = 98, cycles = 0;

  supply_ctl supply_ctl_i (.*);
  serial_ctl_model serial_ctl_model_i (.mclk_i(mclk_i), .ser_o(ser_i));

  always #5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ==================================================================
  // Reporting
  task automatic give_verdict();
    $display("TB: comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic fail(input string s);
    mismatches++;
    $display("MISMATCH at %0t: %s", $time, s);
  endtask
  task automatic check_port(input logic [15:0] got, exp, input string s);
    comparisons++;
    if (got !== exp) fail(s);
  endtask
  task automatic check_word(input note_t n, input logic [31:0] got);
    comparisons++;
    if ((got & n.m) !== (n.v & n.m)) fail("read data");
  endtask

  // Read data taken at the edge that sees waitrequest low
  always @(posedge mclk_i) begin
    if (read_i && waitrequest_o === 1'b0) begin
      if (notes.size() == 0) fail("unexpected read");
      else check_word(notes.pop_front(), readdata_o);
    end
  end

  // ==================================================================
  // Bus master
  task automatic bus_op(input logic rd, input logic [5:0] a,
                        input logic [31:0] d, input logic [31:0] m);
    if (rd) notes.push_back('{d, m});
    @(posedge mclk_i);
    address_i <= a;
    writedata_i <= rd ? 32'h0 : d;
    read_i <= rd;
    write_i <= !rd;
    do begin
      @(posedge mclk_i);
    end while (waitrequest_o !== 1'b0);
    read_i <= 1'b0;
    write_i <= 1'b0;
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [31:0] d);
    bus_op(1'b0, a, d, 32'h0);
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [31:0] v, m);
    bus_op(1'b1, a, v, m);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask
  task automatic do_reset();
    @(posedge mclk_i);
    nrst_i <= 1'b0;
    tick(2);
    nrst_i <= 1'b1;
    tick(2);
  endtask

  // ==================================================================
  // Main sequence
  initial begin
    do_reset();
    rd_reg(`OFS_WINDOW, 32'h20, 32'hFFFF);
    rd_reg(`OFS_OFF_MODE, 32'h0, 32'hF);
    rd_reg(`OFS_OPTIONS, 32'h0, 32'h7);
    rd_reg(6'h3C, 32'h0, 32'hFFFFFFFF);
    check_port({4'h0, vlim_dac_o}, 16'h0, "vlim at reset");
    $display("TB: reset test done");
    serial_ctl_model_i.send(4'b1000, 2'b01, 1'b1);
    check_port({15'h0, loopback_o}, 16'h1, "loopback");
    serial_ctl_model_i.send(4'b0101, 2'b10, 1'b1);
    check_port({15'h0, loopback_o}, 16'h0, "loopback");
    serial_ctl_model_i.send(4'b0010, 2'b00, 1'b1);
    check_port({8'h0, out_latch_o}, 16'h21, "latch hold");
    check_port({12'h0, chip_sel_o}, 16'h4, "chip select");
    serial_ctl_model_i.send(4'b0000, 2'b01, 1'b0);
    check_port({8'h0, out_latch_o}, 16'h20, "latch clear");
    $display("TB: serial test done");
    wr_reg(`OFS_CMD, 32'h1);
    for (int k = 0; k < 4; k++) begin
      r1 = (k == 0) ? `LIM_ZERO : (k == 1) ? `LIM_MAX : 12'($random(seed));
      meas_v_i <= 16'($random(seed)) >> (k * 4);
      wr_reg(`OFS_VLIM, {20'h0, r1});
      wr_reg(`OFS_CLIM, {20'h0, ~r1});
      tick(2);
      check_port({4'h0, vlim_dac_o}, {4'h0, r1}, "vlim code");
      check_port({4'h0, clim_dac_o}, {4'h0, ~r1}, "clim code");
    end
    foreach (mains[k]) begin
      wr_reg(`OFS_MAIN, {16'h0, mains[k]});
      tick(2);
      check_port(main_dac_o, mains[k], "main code");
    end
    $display("TB: code test done");
    r1 = 12'($random(seed));
    r2 = 12'($random(seed));
    wr_reg(`OFS_OFF_VLVL, {20'h0, r1});
    wr_reg(`OFS_OFF_CLVL, {20'h0, r2});
    wr_reg(`OFS_CMD, 32'h2);
    for (int k = 0; k < 16; k++) begin
      mode = 4'(k);
      wr_reg(`OFS_OFF_MODE, {28'h0, mode});
      tick(2);
      check_port({4'h0, (mode[0] ? `LIM_MAX : mode[2] ? r1 : `LIM_ZERO)},
                 {4'h0, vlim_dac_o}, "vlim off");
      check_port({4'h0, (mode[1] ? `LIM_MAX : mode[3] ? r2 : `LIM_ZERO)},
                 {4'h0, clim_dac_o}, "clim off");
    end
    $display("TB: off mode test done");
    wr_reg(`OFS_WINDOW, 32'h55);
    wr_reg(`OFS_CMD, 32'h10);
    wr_reg(`OFS_WINDOW, 32'h66);
    rd_reg(`OFS_WINDOW, 32'h66, 32'hFFFF);
    do_reset();
    rd_reg(`OFS_WINDOW, 32'h20, 32'hFFFF);
    rd_reg(`OFS_OFF_MODE, 32'h0, 32'hF);
    wr_reg(`OFS_CMD, 32'h20);
    rd_reg(`OFS_WINDOW, 32'h20, 32'hFFFF);
    rd_reg(`OFS_OFF_MODE, 32'h0, 32'hF);
    do_reset();
    rd_reg(`OFS_WINDOW, 32'h20, 32'hFFFF);
    $display("TB: storage test done");
    wr_reg(`OFS_OPTIONS, 32'h4);
    rd_reg(`OFS_REPLY, `LINE_FEED, 32'hFF);
    wr_reg(`OFS_OPTIONS, 32'h0);
    wr_reg(`OFS_CMD, 32'h40);
    rd_reg(`OFS_REPLY, `LINE_FEED, 32'hFF);
    $display("TB: line feed test done");
    wr_reg(`OFS_CMD, 32'h1);
    wr_reg(`OFS_MAIN, 32'h1234);
    wr_reg(`OFS_CMD, 32'h8);
    tick(2);
    check_port({15'h0, output_on_o}, 16'h1, "clear kept output");
    check_port(main_dac_o, 16'h1234, "clear kept main");
    wr_reg(`OFS_OPTIONS, 32'h2);
    wr_reg(`OFS_CMD, 32'h8);
    tick(2);
    check_port({14'h0, output_on_o, vmode_o}, 16'h1, "clear reset");
    check_port(main_dac_o, `MAIN_ZERO, "clear zeroed main");
    wr_reg(`OFS_OPTIONS, 32'h3);
    wr_reg(`OFS_CMD, 32'h4);
    tick(2);
    check_port({14'h0, output_on_o, vmode_o}, 16'h3, "reset on");
    wr_reg(`OFS_MAIN, 32'h4321);
    tick(2);
    check_port(main_dac_o, 16'h4321, "reset on main");
    $display("TB: clear test done");
    wr_reg(`OFS_ERR_MASK, 32'h15);
    meas_main_i <= 16'h4331;
    tick(3);
    wr_reg(`OFS_STATUS, 32'hF);
    rd_reg(`OFS_STATUS, 32'h100, 32'h10F);
    meas_main_i <= 16'h4371;
    i_at_limit_i <= 1'b1;
    i_over_hard_i <= 1'b1;
    tick(3);
    rd_reg(`OFS_STATUS, 32'h10F, 32'h10F);
    wr_reg(`OFS_ERR_MASK, 32'h30);
    tick(3);
    check_port({15'h0, output_on_o}, 16'h0, "hard error off");
    $display("TB: error test done");
    give_verdict();
  end
endmodule

bind supply_ctl supply_ctl_assertions #(.NUM_CS(NUM_CS)) chk_i (.*);
